// ===== rtl/ulms_sync.sv
`timescale 1ns/1ps
module ulms_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             i_core_clk,
    input  wire logic             i_resetn,
    // Data.
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ulms_sync_state_t;

    ulms_sync_state_t state_q;
    ulms_sync_state_t state_d;

    if (WIDTH < 1)
    begin : g_width_check
        $error("WIDTH must be at least one");
    end

    // Resets to all ones: the modem pins idle high when nothing drives them.
    always_comb
    begin
        state_d.meta   = i_async;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= '1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_sync = state_q.stable;

endmodule

// ===== rtl/ulms_top.sv
// Summary of operation
// - Framing flag follows receive queue head.
// - Parity flag bit 2 follows queue head.
// - Overrun bit 1 on character into full queue.
// - Bit 0 high while any character held.
// - Four change bits, cleared on status read.
// - Bit 7: not cd, loop gives output two.
// - Bit 6: not ri, loop gives output one.
// - Bit 5: not dsr, loop gives dtr.
// - Bit 4: not cts, loop gives rts.
// - Bit 3 on carrier change, raise interrupt.
// - Bit 2 only on ri rising, interrupt.
// - Any change bit raises modem interrupt.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ulms_top
    import ulms_pkg::*;
(
    // Clock and reset.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_resetn,
    // APB slave.
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [7:0]                 i_paddr,
    input  wire logic [31:0]                i_pwdata,
    output logic      [31:0]                o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    // Receive path status.
    input  wire ulms_pkg::ulms_rx_status_t  i_rx,
    // Modem pins.
    input  wire ulms_pkg::ulms_modem_pins_t i_modem_n,
    // Modem control outputs, active low at the pins.
    output logic                            o_dtr_n,
    output logic                            o_rts_n,
    output logic                            o_out1_n,
    output logic                            o_out2_n,
    // Interrupts.
    output logic                            o_irq,
    output logic                            o_modem_irq
);
    import ulms_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        framing;
        logic        parity;
        logic        overrun;
        logic [3:0]  delta;
        logic [3:0]  level_prev;
        logic [4:0]  modem_control;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic        irq;
        logic        modem_irq;
        logic [3:0]  ctl_out_n;
    } ulms_state_t;

    ulms_state_t      state_q;
    ulms_state_t      state_d;
    ulms_modem_pins_t pins_sync;
    logic [3:0]       level_now;
    logic [7:0]       line_status;
    logic [7:0]       modem_status;
    logic             access;
    logic             rd_line;
    logic             rd_modem;
    logic [3:0]       delta_evt;
    logic             line_evt;

    ////////////////////////////////////////////////////////////////////////

    // The modem pins come from another device and are synchronised first.
    ulms_sync #(
        .WIDTH (4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_async    (i_modem_n),
        .o_sync     (pins_sync)
    );

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] b);
        return a == b;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // Levels in status order: cts, dsr, ri, cd, active high.
    always_comb
    begin
        if (state_q.modem_control[MC_LOOP])
        begin
            level_now[0] = state_q.modem_control[MC_RTS];
            level_now[1] = state_q.modem_control[MC_DTR];
            level_now[2] = state_q.modem_control[MC_OUT1];
            level_now[3] = state_q.modem_control[MC_OUT2];
        end
        else
        begin
            level_now[0] = ~pins_sync.cts_n;
            level_now[1] = ~pins_sync.dsr_n;
            level_now[2] = ~pins_sync.ri_n;
            level_now[3] = ~pins_sync.cd_n;
        end
    end

    // Ring change flags only on the trailing edge of a ring.
    always_comb
    begin
        delta_evt[0] = level_now[0] ^ state_q.level_prev[0];
        delta_evt[1] = level_now[1] ^ state_q.level_prev[1];
        delta_evt[2] = ~level_now[2] & state_q.level_prev[2];
        delta_evt[3] = level_now[3] ^ state_q.level_prev[3];
    end

    always_comb
    begin
        line_status = 8'h00;
        line_status[LS_READY]   = i_rx.data_held;
        line_status[LS_OVERRUN] = state_q.overrun;
        line_status[LS_PARITY]  = state_q.parity;
        line_status[LS_FRAMING] = state_q.framing;
        modem_status = {level_now, state_q.delta};
    end

    assign access   = i_psel & i_penable & state_q.pready;
    assign rd_line  = access & ~i_pwrite
                      & is_addr(i_paddr, ADDR_LINE_STATUS);
    assign rd_modem = access & ~i_pwrite
                      & is_addr(i_paddr, ADDR_MODEM_STATUS);

    // Overrun fires when a character completes into a full queue.
    assign line_evt = (i_rx.char_done & i_rx.fifo_full)
                      | i_rx.head_framing | i_rx.head_parity;

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        state_d = state_q;

        // Answer with one wait state so read data is registered.
        state_d.pready  = i_psel & i_penable & ~state_q.pready;
        state_d.pslverr = 1'b0;
        if (i_psel & i_penable & ~state_q.pready)
        begin
            state_d.prdata = 32'h0000_0000;
            if (is_addr(i_paddr, ADDR_LINE_STATUS))
            begin
                state_d.prdata[7:0] = line_status;
            end
            else if (is_addr(i_paddr, ADDR_MODEM_STATUS))
            begin
                state_d.prdata[7:0] = modem_status;
            end
            else if (is_addr(i_paddr, ADDR_MODEM_CONTROL))
            begin
                state_d.prdata[4:0] = state_q.modem_control;
            end
            else if (is_addr(i_paddr, ADDR_IRQ_STATUS))
            begin
                state_d.prdata[1:0] = state_q.irq_status;
            end
            else if (is_addr(i_paddr, ADDR_IRQ_MASK))
            begin
                state_d.prdata[1:0] = state_q.irq_mask;
            end
            else
            begin
                state_d.pslverr = 1'b1;
            end
        end

        // Only flags that the read reported are cleared: an error landing
        // between the data capture and the end of the access would
        // otherwise be lost unseen. A fresh error in that cycle survives.
        if (rd_line)
        begin
            state_d.framing = state_q.framing
                              & ~state_q.prdata[LS_FRAMING];
            state_d.parity  = state_q.parity
                              & ~state_q.prdata[LS_PARITY];
            state_d.overrun = state_q.overrun
                              & ~state_q.prdata[LS_OVERRUN];
        end
        if (i_rx.head_framing)
        begin
            state_d.framing = 1'b1;
        end
        if (i_rx.head_parity)
        begin
            state_d.parity = 1'b1;
        end
        if (i_rx.char_done & i_rx.fifo_full)
        begin
            state_d.overrun = 1'b1;
        end

        // Change flags clear on read once reported; a new change wins.
        if (rd_modem)
        begin
            state_d.delta = state_q.delta & ~state_q.prdata[3:0];
        end
        state_d.delta      = state_d.delta | delta_evt;
        state_d.level_prev = level_now;

        if (access & i_pwrite)
        begin
            if (is_addr(i_paddr, ADDR_MODEM_CONTROL))
            begin
                state_d.modem_control = i_pwdata[4:0];
            end
            else if (is_addr(i_paddr, ADDR_IRQ_MASK))
            begin
                state_d.irq_mask = i_pwdata[1:0];
            end
            else if (is_addr(i_paddr, ADDR_IRQ_STATUS))
            begin
                state_d.irq_status = state_q.irq_status & ~i_pwdata[1:0];
            end
        end

        // Sticky events, set wins over a write-one clear.
        if (line_evt)
        begin
            state_d.irq_status[IRQ_LINE] = 1'b1;
        end
        if (|delta_evt)
        begin
            state_d.irq_status[IRQ_MODEM] = 1'b1;
        end

        state_d.irq = |(state_d.irq_status & state_d.irq_mask);
        // Modem interrupt level follows the change bits directly.
        state_d.modem_irq = |state_d.delta;

        // Outputs are inactive while looped back, as the pins are cut off.
        if (state_d.modem_control[MC_LOOP])
        begin
            state_d.ctl_out_n = 4'hF;
        end
        else
        begin
            state_d.ctl_out_n = ~state_d.modem_control[3:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q               <= '0;
            state_q.level_prev    <= 4'h0;
            state_q.modem_control <= MODEM_CONTROL_RST;
            state_q.irq_mask      <= IRQ_MASK_RST;
            state_q.ctl_out_n     <= MODEM_LEVEL_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign o_prdata    = state_q.prdata;
    assign o_pready    = state_q.pready;
    assign o_pslverr   = state_q.pslverr;
    assign o_dtr_n     = state_q.ctl_out_n[MC_DTR];
    assign o_rts_n     = state_q.ctl_out_n[MC_RTS];
    assign o_out1_n    = state_q.ctl_out_n[MC_OUT1];
    assign o_out2_n    = state_q.ctl_out_n[MC_OUT2];
    assign o_irq       = state_q.irq;
    assign o_modem_irq = state_q.modem_irq;

endmodule

// ===== shared/ulms_pkg.sv
package ulms_pkg;

    // Register byte addresses on the APB.
    localparam logic [7:0] ADDR_LINE_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_MODEM_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'h10;

    // Line status field positions.
    localparam int LS_READY   = 0;
    localparam int LS_OVERRUN = 1;
    localparam int LS_PARITY  = 2;
    localparam int LS_FRAMING = 3;

    // Modem control field positions.
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;

    // Interrupt status field positions.
    localparam int IRQ_LINE  = 0;
    localparam int IRQ_MODEM = 1;

    // Reset values.
    localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
    localparam logic [1:0] IRQ_MASK_RST      = 2'h0;
    localparam logic [3:0] MODEM_LEVEL_RST   = 4'hF;

    // Modem input pins, all active low, in status order cts, dsr, ri, cd.
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ulms_modem_pins_t;

    // Receive path events and levels at the head of the receive queue.
    typedef struct packed {
        logic char_done;
        logic fifo_full;
        logic head_framing;
        logic head_parity;
        logic data_held;
    } ulms_rx_status_t;

endpackage

// ===== test/test_ulms_top.sv
`timescale 1ns/1ps
module test_ulms_top;
    import ulms_pkg::*;
    logic             i_core_clk = 1'b0;
    logic             i_resetn   = 1'b0;
    logic             i_psel     = 1'b0;
    logic             i_penable  = 1'b0;
    logic             i_pwrite   = 1'b0;
    logic [7:0]       i_paddr    = 8'h00;
    logic [31:0]      i_pwdata   = 32'h0;
    ulms_rx_status_t  i_rx       = '0;
    logic [3:0]       lvl_n      = 4'hF;
    ulms_modem_pins_t modem_n;
    logic [31:0]      o_prdata;
    logic             o_pready, o_pslverr, o_irq, o_modem_irq;
    logic             o_dtr_n, o_rts_n, o_out1_n, o_out2_n;
    logic [31:0]      rd;
    logic             err;
    int               fail_count = 0;
    int               check_count = 0;
    always #20 i_core_clk = ~i_core_clk;
    ulms_top dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx(i_rx),
        .i_modem_n(modem_n), .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n),
        .o_out1_n(o_out1_n), .o_out2_n(o_out2_n), .o_irq(o_irq),
        .o_modem_irq(o_modem_irq));
    ulms_modem_model u_modem (.i_core_clk(i_core_clk),
        .i_level_n(lvl_n), .o_pins(modem_n));
    ////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    // The wait is bounded so a dead slave ends as a mismatch, not a hang.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        chk("pready", 1'b1, o_pready);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic pins(input logic [3:0] v);
        lvl_n <= v;
        idle(8);
    endtask
    task automatic outs(input logic [3:0] e);
        chk("pins", e, {o_dtr_n, o_rts_n, o_out1_n, o_out2_n});
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        outs(4'hF);
        rdc(ADDR_MODEM_CONTROL, 32'h0);
        rdc(ADDR_IRQ_MASK, 32'h0);
        rdc(ADDR_LINE_STATUS, 32'h0);
        rdc(ADDR_MODEM_STATUS, 32'h0);
        rdc(8'h20, 32'h0);
        chk("slverr", 1'b1, err);
        apb(1'b1, 8'h24, 32'hFF);
        chk("slverr", 1'b1, err);
        $display("test reset done");
    endtask
    task automatic t_line();
        i_rx <= 5'h11;
        @(posedge i_core_clk);
        i_rx <= 5'h01;
        idle(3);
        rdc(ADDR_LINE_STATUS, 32'h01);
        i_rx <= 5'h1F;
        @(posedge i_core_clk);
        i_rx <= 5'h01;
        idle(3);
        rdc(ADDR_LINE_STATUS, 32'h0F);
        rdc(ADDR_LINE_STATUS, 32'h01);
        i_rx <= 5'h00;
        idle(3);
        rdc(ADDR_LINE_STATUS, 32'h00);
        $display("test line done");
    endtask
    task automatic t_modem();
        pins(4'b0111);
        chk("modem_irq", 1'b1, o_modem_irq);
        rdc(ADDR_MODEM_STATUS, 32'h88);
        idle(1);
        chk("modem_irq", 1'b0, o_modem_irq);
        rdc(ADDR_MODEM_STATUS, 32'h80);
        pins(4'b0011);
        rdc(ADDR_MODEM_STATUS, 32'hC0);
        pins(4'b0111);
        rdc(ADDR_MODEM_STATUS, 32'h84);
        pins(4'b0100);
        rdc(ADDR_MODEM_STATUS, 32'hB3);
        pins(4'hF);
        rdc(ADDR_MODEM_STATUS, 32'h0B);
        $display("test modem done");
    endtask
    task automatic t_loop();
        apb(1'b1, ADDR_MODEM_CONTROL, 32'h15);
        idle(8);
        outs(4'hF);
        rdc(ADDR_MODEM_STATUS, 32'h62);
        apb(1'b1, ADDR_MODEM_CONTROL, 32'h0B);
        idle(8);
        outs(4'h2);
        rdc(ADDR_MODEM_CONTROL, 32'h0B);
        rdc(ADDR_MODEM_STATUS, 32'h06);
        rdc(ADDR_MODEM_STATUS, 32'h0);
        $display("test loop done");
    endtask
    task automatic t_irq();
        rdc(ADDR_IRQ_STATUS, 32'h3);
        chk("irq masked", 1'b0, o_irq);
        apb(1'b1, ADDR_IRQ_MASK, 32'h3);
        idle(3);
        chk("irq", 1'b1, o_irq);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        rdc(ADDR_IRQ_STATUS, 32'h2);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h2);
        rdc(ADDR_IRQ_STATUS, 32'h0);
        idle(3);
        chk("irq clear", 1'b0, o_irq);
        rdc(ADDR_IRQ_MASK, 32'h3);
        $display("test irq done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        idle(6);
        i_resetn <= 1'b1;
        t_reset();
        t_line();
        t_modem();
        t_loop();
        t_irq();
        stop_test();
    end
    initial
    begin
        #200us;
        fail_count++;
        stop_test();
    end
endmodule

// ===== test/ulms_checker.sv
`timescale 1ns/1ps
module ulms_checker
    import ulms_pkg::*;
(
    // Watched ports.
    input wire logic                     i_core_clk,
    input wire logic                     i_resetn,
    input wire logic                     i_psel,
    input wire logic                     i_penable,
    input wire logic                     i_pwrite,
    input wire logic [7:0]               i_paddr,
    input wire logic [31:0]              o_prdata,
    input wire logic                     o_pready,
    input wire logic                     o_pslverr,
    input wire ulms_pkg::ulms_rx_status_t i_rx,
    input wire logic                     o_irq,
    input wire logic                     o_modem_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    logic rd_ls;
    logic rd_ms;
    assign rd_ls = o_pready && !i_pwrite && i_paddr == ADDR_LINE_STATUS;
    assign rd_ms = o_pready && !i_pwrite && i_paddr == ADDR_MODEM_STATUS;
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_ready_time: assert property
        (i_psel && i_penable && !$past(i_penable) |=> o_pready)
        else $error("pready late");
    a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
        else $error("pready without access");
    a_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 0)
        else $error("bad error response");
    a_err_unmapped: assert property
        (o_pready && i_paddr > ADDR_IRQ_MASK |-> o_pslverr)
        else $error("unmapped not refused");
    a_err_mapped: assert property (o_pready && i_paddr[1:0] == 2'h0
        && i_paddr <= ADDR_IRQ_MASK |-> !o_pslverr)
        else $error("mapped refused");
    a_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ready_bit: assert property
        (rd_ls |-> o_prdata[LS_READY] == $past(i_rx.data_held))
        else $error("ready bit wrong");
    a_modem_irq_on: assert property
        (rd_ms && o_prdata[3:0] != 4'h0 |-> o_modem_irq)
        else $error("modem irq missing");
    a_modem_irq_off: assert property
        (rd_ms && o_prdata[3:0] == 4'h0 |-> ##2 !o_modem_irq)
        else $error("modem irq stuck");
    c_err: cover property (o_pslverr);
    c_modem: cover property ($rose(o_modem_irq));
    c_irq: cover property ($rose(o_irq));
endmodule
bind ulms_top ulms_checker u_chk (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx(i_rx),
    .o_irq(o_irq), .o_modem_irq(o_modem_irq));

// ===== test/ulms_modem_model.sv
`timescale 1ns/1ps
module ulms_modem_model
    import ulms_pkg::*;
(
    // Clock and wanted levels.
    input  wire logic                  i_core_clk,
    input  wire logic [3:0]            i_level_n,
    // Modem pins.
    output ulms_pkg::ulms_modem_pins_t o_pins
);
    // Levels move only after an edge; the design must still sync them.
    always_ff @(posedge i_core_clk)
    begin
        o_pins <= i_level_n;
    end
endmodule
